// File: dsu_pkg.sv
package dsu_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  // Nominal width of an external update pulse on a free bus line
  localparam int PULSE_NOMINAL_NS = 1000;
  // Least time a line must stay high before it counts as a pulse
  localparam int PULSE_QUAL_NS = 500;
  localparam int PULSE_QUAL_CYC = (PULSE_QUAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int QCNT_W = 5;
  localparam logic [QCNT_W-1:0] QUAL_LAST = QCNT_W'(PULSE_QUAL_CYC - 1);
  localparam logic [QCNT_W-1:0] QCNT_ZERO = 5'h00;
  localparam logic [QCNT_W-1:0] QCNT_ONE = 5'h01;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [4:0] FN_ANGLE_WRITE = 5'h10;
  localparam logic [4:0] FN_MODE_WRITE = 5'h11;
  localparam logic [4:0] FN_EXECUTE = 5'h19;
  localparam logic [3:0] SUB_LOW = 4'h0;
  localparam logic [3:0] SUB_HIGH = 4'h1;

  // ----------------------------------------------------------------
  // Dataway write-line field positions (index k holds line k+1)
  // ----------------------------------------------------------------
  localparam int W_WIDTH = 24;
  localparam int ANGLE_W = 16;
  localparam int BYTE_W = 8;
  localparam int CH1_MSB = 23;
  localparam int CH1_LSB = 8;
  localparam int CH2H_MSB = 7;
  localparam int CH2H_LSB = 0;
  localparam int CH2L_MSB = 23;
  localparam int CH2L_LSB = 16;
  localparam int CH3_MSB = 15;
  localparam int CH3_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int MODE_LSB = 0;

  // ----------------------------------------------------------------
  // Transfer modes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_EITHER = 3'h4;
  localparam logic [2:0] MODE_P2 = 3'h5;
  localparam logic [2:0] MODE_P1 = 3'h6;
  localparam logic [2:0] MODE_P2_THEN_P1 = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [15:0] ANGLE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic n;
    logic s1;
    logic s2;
    logic z;
    logic [4:0] f;
    logic [3:0] a;
  } dsu_ctl_t;

  localparam int CTL_W = 13;

  typedef struct packed {
    logic [15:0] ch3;
    logic [15:0] ch2;
    logic [15:0] ch1;
  } dsu_angles_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_STROBE = 2'b10,
    CYC_HOLD = 2'b11
  } dsu_cyc_t;

  typedef enum logic {
    SEQ_WAIT_P2 = 1'b0,
    SEQ_ARMED = 1'b1
  } dsu_seq_t;

endpackage

// File: dsu_sync.sv
module dsu_sync
  import dsu_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Raw pins
  input wire logic [WIDTH-1:0] d_in,
  // Filtered level
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] next_q;

  // A bit only moves once the last two stages agree, which hides
  // a single-cycle disagreement while a pin is still settling
  assign agree = ~(stage2 ^ stage3);
  assign next_q = (agree & stage3) | (~agree & q_out);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      q_out <= '0;
    end else begin
      stage1 <= d_in;
      stage2 <= stage1;
      stage3 <= stage2;
      q_out <= next_q;
    end
  end

endmodule

// File: dsu_chan.sv
module dsu_chan
  import dsu_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Staging loads
  input wire logic hi_we_in,
  input wire logic [BYTE_W-1:0] hi_in,
  input wire logic lo_we_in,
  input wire logic [BYTE_W-1:0] lo_in,
  // Update
  input wire logic xfer_in,
  // Holding value for the converter
  output logic [ANGLE_W-1:0] angle_out
);

  logic [ANGLE_W-1:0] staging;
  logic [BYTE_W-1:0] next_hi;
  logic [BYTE_W-1:0] next_lo;

  // Untouched bytes keep their contents
  assign next_hi = hi_we_in ? hi_in : staging[ANGLE_W-1:BYTE_W];
  assign next_lo = lo_we_in ? lo_in : staging[BYTE_W-1:0];

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      staging <= ANGLE_RESET;
    end else begin
      staging <= {next_hi, next_lo};
    end
  end

  // Holding moves only on an update; the old staging value is taken
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      angle_out <= ANGLE_RESET;
    end else if (xfer_in) begin
      angle_out <= staging;
    end
  end

endmodule

// File: dsu_top.sv
module dsu_top
  import dsu_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Dataway command and strobes
  input wire dsu_ctl_t ctl_in,
  // Dataway write lines, index k is line k+1
  input wire logic [W_WIDTH-1:0] w_in,
  // Free bus update lines
  input wire logic p1_in,
  input wire logic p2_in,
  // Dataway responses
  output logic q_out,
  output logic x_out,
  // Converter side
  output dsu_angles_t angles_out,
  output logic xfer_out,
  // Status
  output logic [2:0] mode_out,
  output logic armed_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] ctl_sync;
  logic [W_WIDTH-1:0] w_sync;
  logic [1:0] pline_sync;
  dsu_ctl_t ctl;

  dsu_sync #(
    .WIDTH(CTL_W)
  ) u_ctl_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .d_in(ctl_in),
    .q_out(ctl_sync)
  );

  dsu_sync #(
    .WIDTH(W_WIDTH)
  ) u_w_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .d_in(w_in),
    .q_out(w_sync)
  );

  dsu_sync #(
    .WIDTH(2)
  ) u_pline_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .d_in({p2_in, p1_in}),
    .q_out(pline_sync)
  );

  assign ctl = dsu_ctl_t'(ctl_sync);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire cmd_angle_low = (ctl.f == FN_ANGLE_WRITE) && (ctl.a == SUB_LOW);
  wire cmd_angle_high = (ctl.f == FN_ANGLE_WRITE) && (ctl.a == SUB_HIGH);
  wire cmd_mode = (ctl.f == FN_MODE_WRITE) && (ctl.a == SUB_LOW);
  wire cmd_exec = (ctl.f == FN_EXECUTE) && (ctl.a == SUB_LOW);
  wire cmd_valid = cmd_angle_low | cmd_angle_high | cmd_mode | cmd_exec;

  // ----------------------------------------------------------------
  // Dataway cycle tracking
  // ----------------------------------------------------------------
  // One action per addressed cycle: a strobe that bounces or a long N
  // must not repeat a write or a transfer
  dsu_cyc_t cyc;
  dsu_cyc_t next_cyc;
  logic s2_prev;
  wire go;
  wire init_go;

  assign go = (cyc == CYC_ADDR) & ctl.n & ctl.s1;
  // Initialize is unaddressed and acts at the second strobe
  assign init_go = ctl.z & ctl.s2 & ~s2_prev;

  always_comb begin
    next_cyc = cyc;
    case (cyc)
      CYC_IDLE: begin
        if (ctl.n) begin
          next_cyc = CYC_ADDR;
        end
      end
      CYC_ADDR: begin
        if (!ctl.n) begin
          next_cyc = CYC_IDLE;
        end else if (ctl.s1) begin
          next_cyc = CYC_STROBE;
        end
      end
      CYC_STROBE: begin
        if (!ctl.n) begin
          next_cyc = CYC_IDLE;
        end else if (!ctl.s1) begin
          next_cyc = CYC_HOLD;
        end
      end
      CYC_HOLD: begin
        if (!ctl.n) begin
          next_cyc = CYC_IDLE;
        end
      end
      default: begin
        next_cyc = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cyc <= CYC_IDLE;
      s2_prev <= 1'b0;
    end else begin
      cyc <= next_cyc;
      s2_prev <= ctl.s2;
    end
  end

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  // Both answers follow N, so an unaddressed or unknown command
  // leaves the response lines quiet
  wire next_q = ctl.n & cmd_valid;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_out <= 1'b0;
      x_out <= 1'b0;
    end else begin
      q_out <= next_q;
      x_out <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Transfer mode register
  // ----------------------------------------------------------------
  logic [2:0] mode;
  wire mode_we;

  assign mode_we = go & cmd_mode;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode <= MODE_RESET;
    end else if (init_go) begin
      mode <= MODE_RESET;
    end else if (mode_we) begin
      mode <= w_sync[MODE_MSB:MODE_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Update pulse qualification
  // ----------------------------------------------------------------
  // A line must stay high for half the nominal width before it counts,
  // so short noise on the free bus lines does not update the outputs;
  // each pulse fires once however long it lasts
  logic [QCNT_W-1:0] pcnt [2];
  logic [1:0] pfire;

  for (genvar gi = 0; gi < 2; gi++) begin : g_pq
    assign pfire[gi] = pline_sync[gi] & (pcnt[gi] == QUAL_LAST);
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        pcnt[gi] <= QCNT_ZERO;
      end else if (!pline_sync[gi]) begin
        pcnt[gi] <= QCNT_ZERO;
      end else if (pcnt[gi] != QUAL_LAST + QCNT_ONE) begin
        pcnt[gi] <= pcnt[gi] + QCNT_ONE;
      end
    end
  end

  wire p1_hit = pfire[0];
  wire p2_hit = pfire[1];

  // ----------------------------------------------------------------
  // Mode selection of the external update
  // ----------------------------------------------------------------
  wire seq_fire;
  wire xfer_ext;
  wire xfer;
  wire seq_new7 = init_go | (w_sync[MODE_MSB:MODE_LSB] == MODE_P2_THEN_P1);

  // Modes 0 to 3 match none of these and leave the lines without effect
  wire mode_either = (mode == MODE_EITHER);
  wire mode_p2 = (mode == MODE_P2);
  wire mode_p1 = (mode == MODE_P1);
  wire mode_seq = (mode == MODE_P2_THEN_P1);

  // ----------------------------------------------------------------
  // Two-pulse sequence for mode 7
  // ----------------------------------------------------------------
  dsu_seq_t seq;
  dsu_seq_t next_seq;

  assign seq_fire = mode_seq & (seq == SEQ_ARMED) & p1_hit;

  // A fresh P2 in the same cycle as the firing P1 re-arms, so that
  // pulse is not lost
  always_comb begin
    next_seq = seq;
    case (seq)
      SEQ_WAIT_P2: begin
        if (mode_seq && p2_hit) begin
          next_seq = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (!mode_seq) begin
          next_seq = SEQ_WAIT_P2;
        end else if (p1_hit && !p2_hit) begin
          next_seq = SEQ_WAIT_P2;
        end
      end
      default: begin
        next_seq = SEQ_WAIT_P2;
      end
    endcase
    // A mode write or initialize starts the sequence afresh, yet a P2
    // firing in that cycle still arms a new mode 7: the set wins
    if (init_go || mode_we) begin
      next_seq = SEQ_WAIT_P2;
      if (p2_hit && seq_new7) begin
        next_seq = SEQ_ARMED;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seq <= SEQ_WAIT_P2;
    end else begin
      seq <= next_seq;
    end
  end

  assign xfer_ext = (mode_either & (p1_hit | p2_hit))
                  | (mode_p2 & p2_hit)
                  | (mode_p1 & p1_hit)
                  | seq_fire;
  assign xfer = xfer_ext | (go & cmd_exec);

  // ----------------------------------------------------------------
  // Staging and holding registers
  // ----------------------------------------------------------------
  wire wr_low = go & cmd_angle_low;
  wire wr_high = go & cmd_angle_high;

  // Channel 1 takes the top sixteen lines of the low write
  dsu_chan u_ch1 (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .hi_we_in(wr_low),
    .hi_in(w_sync[CH1_MSB:CH1_LSB+BYTE_W]),
    .lo_we_in(wr_low),
    .lo_in(w_sync[CH1_LSB+BYTE_W-1:CH1_LSB]),
    .xfer_in(xfer),
    .angle_out(angles_out.ch1)
  );

  // Channel 2 is split across both writes
  dsu_chan u_ch2 (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .hi_we_in(wr_low),
    .hi_in(w_sync[CH2H_MSB:CH2H_LSB]),
    .lo_we_in(wr_high),
    .lo_in(w_sync[CH2L_MSB:CH2L_LSB]),
    .xfer_in(xfer),
    .angle_out(angles_out.ch2)
  );

  // Channel 3 takes the bottom sixteen lines of the high write
  dsu_chan u_ch3 (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .hi_we_in(wr_high),
    .hi_in(w_sync[CH3_MSB:CH3_LSB+BYTE_W]),
    .lo_we_in(wr_high),
    .lo_in(w_sync[CH3_LSB+BYTE_W-1:CH3_LSB]),
    .xfer_in(xfer),
    .angle_out(angles_out.ch3)
  );

  // ----------------------------------------------------------------
  // Converter strobe and status
  // ----------------------------------------------------------------
  // Angles pass as plain unsigned binary, MSB worth half a turn; the
  // strobe is high in the first cycle the new holding value shows
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      xfer_out <= 1'b0;
      mode_out <= MODE_RESET;
      armed_out <= 1'b0;
    end else begin
      xfer_out <= xfer;
      mode_out <= mode;
      armed_out <= (next_seq == SEQ_ARMED);
    end
  end

endmodule

// File: dsu_ctrl_model.sv
module dsu_ctrl_model
  import dsu_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Dataway drive
  output dsu_ctl_t ctl_out,
  output logic [W_WIDTH-1:0] w_out,
  output logic p1_out,
  output logic p2_out,
  // Responses
  input wire logic q_in,
  input wire logic x_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ctl_out = '0;
    w_out = 24'h5A5A5A;
    p1_out = 1'b0;
    p2_out = 1'b0;
  end

  // --------------------------------
  // Dataway cycles, all on falling edge
  // --------------------------------
  task automatic cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w,
                     output logic q, output logic x);
    @(negedge mclk_in);
    ctl_out.n = 1'b1;
    ctl_out.f = f;
    ctl_out.a = a;
    w_out = w;
    repeat (6) @(negedge mclk_in);
    ctl_out.s1 = 1'b1;
    repeat (6) @(negedge mclk_in);
    q = q_in;
    x = x_in;
    ctl_out.s1 = 1'b0;
    repeat (6) @(negedge mclk_in);
    // Released lines must not keep looking like the last command
    ctl_out.n = 1'b0;
    ctl_out.f = ~f;
    ctl_out.a = ~a;
    w_out = ~w;
    repeat (8) @(negedge mclk_in);
  endtask

  task automatic init_dw;
    @(negedge mclk_in);
    ctl_out.z = 1'b1;
    ctl_out.s2 = 1'b1;
    repeat (8) @(negedge mclk_in);
    ctl_out.s2 = 1'b0;
    repeat (6) @(negedge mclk_in);
    ctl_out.z = 1'b0;
    repeat (6) @(negedge mclk_in);
  endtask

  // One microsecond is 25 cycles at 40 ns
  task automatic pulse(input logic sel);
    @(negedge mclk_in);
    if (sel) p2_out = 1'b1;
    else p1_out = 1'b1;
    repeat (25) @(negedge mclk_in);
    p1_out = 1'b0;
    p2_out = 1'b0;
    repeat (12) @(negedge mclk_in);
  endtask
endmodule

// File: dsu_top_chk.sv
module dsu_top_chk
  import dsu_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Design inputs
  input wire dsu_ctl_t ctl_in,
  input wire logic [W_WIDTH-1:0] w_in,
  input wire logic p1_in,
  input wire logic p2_in,
  // Design outputs
  input wire logic q_out,
  input wire logic x_out,
  input wire dsu_angles_t angles_out,
  input wire logic xfer_out,
  input wire logic [2:0] mode_out,
  input wire logic armed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  wire ex = ctl_in.n && ctl_in.f == FN_EXECUTE && ctl_in.a == SUB_LOW;
  wire ok_fa = ex || (ctl_in.f == FN_ANGLE_WRITE && ctl_in.a <= SUB_HIGH)
               || (ctl_in.f == FN_MODE_WRITE && ctl_in.a == SUB_LOW);
  // Line-triggered transfer, not caused by the execute command
  wire hw = xfer_out && !ex;

  a_qx_same: assert property (q_out == x_out)
    else $error("q and x differ");
  a_q_valid: assert property ($rose(q_out) |-> ctl_in.n && ok_fa)
    else $error("q without a valid command");
  // One cause gives one strobe; two live lines may fire in adjacent cycles
  a_xfer_pulse: assert property (xfer_out && $countones({ex, p1_in, p2_in}) == 1 |=>
    !xfer_out)
    else $error("transfer strobe too long");
  a_hold_cause: assert property ($changed(angles_out) |-> xfer_out)
    else $error("outputs moved without transfer");
  a_xfer_cause: assert property (xfer_out |-> ex || p1_in || p2_in)
    else $error("transfer without cause");
  a_low_quiet: assert property (hw |-> mode_out[2])
    else $error("line transfer in unused mode");
  a_mode5_p2: assert property (hw && mode_out == MODE_P2 |-> p2_in)
    else $error("mode 5 took another line");
  a_mode6_p1: assert property (hw && mode_out == MODE_P1 |-> p1_in)
    else $error("mode 6 took another line");
  a_mode7_seq: assert property (hw && mode_out == MODE_P2_THEN_P1 |->
    p1_in && $past(armed_out))
    else $error("mode 7 fired out of order");
  // The mode copy lags one cycle, so a mode 7 written with the arming P2 shows next
  a_arm_p2: assert property ($rose(armed_out) |-> p2_in ##1
    mode_out == MODE_P2_THEN_P1)
    else $error("armed without p2");
  a_exec_fire: assert property ($rose(ctl_in.s1) && ex |-> ##[1:12] xfer_out)
    else $error("execute gave no transfer");
  a_mode_cmd: assert property ($changed(mode_out) |-> ctl_in.n || ctl_in.z)
    else $error("mode moved without command");

  c_exec: cover property (xfer_out && ex);
  c_line: cover property (hw && p1_in);
  c_arm: cover property ($rose(armed_out));
endmodule

bind dsu_top dsu_top_chk u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ctl_in(ctl_in),
  .w_in(w_in), .p1_in(p1_in), .p2_in(p2_in), .q_out(q_out), .x_out(x_out),
  .angles_out(angles_out), .xfer_out(xfer_out), .mode_out(mode_out), .armed_out(armed_out));

// File: dsu_top_tb.sv
module dsu_top_tb
  import dsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  dsu_ctl_t ctl_in;
  logic [W_WIDTH-1:0] w_in;
  logic p1_in, p2_in, q_out, x_out, xfer_out, armed_out;
  logic [2:0] mode_out;
  dsu_angles_t angles_out, st, hold;
  logic qv, xv, arm, go;
  int bad_count = 0;
  int n_compared = 0;
  int n_xfer = 0;
  int x_exp = 0;

  always #20 mclk_in = ~mclk_in;

  // Strobes are counted where they stand settled, away from their launching edge
  always @(negedge mclk_in) if (xfer_out === 1'b1) n_xfer++;

  dsu_top dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ctl_in(ctl_in), .w_in(w_in),
    .p1_in(p1_in), .p2_in(p2_in), .q_out(q_out), .x_out(x_out), .angles_out(angles_out),
    .xfer_out(xfer_out), .mode_out(mode_out), .armed_out(armed_out));
  dsu_ctrl_model u_ctrl (.mclk_in(mclk_in), .ctl_out(ctl_in), .w_out(w_in),
    .p1_out(p1_in), .p2_out(p2_in), .q_in(q_out), .x_in(x_out));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w,
                     input logic e);
    u_ctrl.cmd(f, a, w, qv, xv);
    check(48'({qv, xv}), 48'({e, e}), "q x");
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] w);
    cmd(FN_ANGLE_WRITE, a, w, 1'b1);
    if (a == SUB_LOW) begin
      st.ch1 = w[23:8];
      st.ch2[15:8] = w[7:0];
    end else begin
      st.ch2[7:0] = w[23:16];
      st.ch3 = w[15:0];
    end
  endtask

  task automatic exec;
    cmd(FN_EXECUTE, SUB_LOW, 24'h000000, 1'b1);
    hold = st;
    x_exp++;
    check(angles_out, hold, "exec");
    check(48'(n_xfer), 48'(x_exp), "strobes");
  endtask

  // Upper lines set so only W3..W1 may count
  task automatic put_mode(input logic [2:0] m);
    cmd(FN_MODE_WRITE, SUB_LOW, {21'h1FFFFF, m}, 1'b1);
    arm = 1'b0;
    check(48'(mode_out), 48'(m), "mode");
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    st = '0;
    hold = '0;
    arm = 1'b0;
    repeat (12) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    check(48'(mode_out), 48'(MODE_RESET), "reset mode");
    check(angles_out, 48'h000000000000, "reset angles");
    $display("test reset done");
    wr(SUB_LOW, 24'hABCDEF);
    wr(SUB_HIGH, 24'h123456);
    check(angles_out, hold, "staged only");
    exec;
    check(angles_out, 48'h3456EF12ABCD, "packing");
    wr(SUB_LOW, 24'h111122);
    exec;
    check(angles_out, 48'h345622121111, "partial");
    $display("test packing done");
    cmd(FN_ANGLE_WRITE, 4'h2, 24'h777777, 1'b0);
    cmd(FN_MODE_WRITE, SUB_HIGH, 24'h000000, 1'b0);
    cmd(FN_EXECUTE, SUB_HIGH, 24'h000000, 1'b0);
    cmd(5'h00, SUB_LOW, 24'h000000, 1'b0);
    check(angles_out, hold, "refused");
    check(48'(mode_out), 48'(MODE_RESET), "refused mode");
    exec;
    $display("test refused done");
    for (int m = 0; m < 8; m++) begin
      put_mode(3'(m));
      for (int k = 0; k < 3; k++) begin
        wr(SUB_LOW, {16'hC3A5, 1'b0, 3'(m), 4'(k)});
        u_ctrl.pulse(k == 1);
        go = (m == 4) || (m == 5 && k == 1) || (m == 6 && k != 1) || (m == 7 && k != 1 && arm);
        if (m == 7) arm = (k == 1);
        if (go) begin
          hold = st;
          x_exp++;
        end
        check(angles_out, hold, "line pulse");
        check(48'(n_xfer), 48'(x_exp), "line strobes");
        check(48'(armed_out), 48'(arm), "armed");
      end
    end
    $display("test modes done");
    put_mode(MODE_EITHER);
    u_ctrl.init_dw;
    check(48'(mode_out), 48'(MODE_RESET), "init");
    wr(SUB_HIGH, 24'h9876FE);
    u_ctrl.pulse(1'b0);
    check(angles_out, hold, "init p1");
    put_mode(3'h0);
    exec;
    $display("test init done");
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    finish_test;
  end
endmodule
